// [adc_consts.svh]
// Operation
// (RL1) single-ended codes 0..11 select inputs 0..11 against ground; upper-11 reserved
// (RL2) differential pairs adjacent inputs; odd code swaps polarity; upper-11 reserved
// (RL3) four-channel variant forces the two upper code bits to zero
// (RL4) ref-pin mode ignores single-ended top input; scans end at 2 or 10
// (RL5) ref-pin mode top pair reads ground against input 2 or 10
// (RL6) differential scan steps the code by two up to the upper-bit limit
// (RL7) results are handed out only inside a read transaction
// (RL8) read starts with START, address, read bit; device acks good address
// (RL9) each result is two bytes: six high bits then ten bits msb first
// (RL10) master acks to continue or nacks to end after each byte
// (RL11) on a nack the device releases SDA
// (RL12) clock-source bit picks conversion clock; power-up value selects internal
// (RL13) input-mode bit: 1 single-ended, 0 differential; power-up single-ended
// (RL14) ref-pin mode takes the top input out of multichannel scans
// (RL15) channel, input-mode and ref-pin settings are held until rewritten or reset
`ifndef ADC_CONSTS_SVH
`define ADC_CONSTS_SVH
`define CODE_W        4
`define RES_W         10
`define WORD_W        16
`define LEAD_ONES     6'h3f
`define ALL_ONES      16'hffff
`define TOP_SMALL     4'h3
`define TOP_LARGE     4'hb
`define RESERVED_HI   2'b11
`define FOUR_CH_MASK  4'h3
`define SGL_STEP      4'h1
`define DIFF_STEP     4'h2
`define CFG_CHAN_RST  4'h0
`define CFG_SGL_RST   1'b1
`define CFG_REF_RST   1'b0
`define CFG_EXT_RST   1'b0
`define CFG_SCAN_RST  1'b0
`define BIT_LAST      4'h7
`define BIT_ADDR_END  4'h8
`define RW_READ       1'b1
`endif

// [adc_i2c_readout.sv]
`include "adc_consts.svh"
module adc_i2c_readout #(
  parameter logic [6:0] SLAVE_ADDR = 7'h2a, // arbitrary value
  parameter bit         FOUR_CHAN  = 1'b0,
  parameter int         FIFO_DEPTH = 4
)(
  // system clock domain
  input  wire logic               i_ref_clk,
  input  wire logic               i_reset_n,
  // link clock domain
  input  wire logic               i_link_clk,
  // configuration
  input  wire logic               i_cfg_write,
  input  wire logic [`CODE_W-1:0] i_cfg_chan,
  input  wire logic               i_cfg_single,
  input  wire logic               i_cfg_ref_pin,
  input  wire logic               i_cfg_ext_clk,
  input  wire logic               i_cfg_scan,
  // converter
  output logic                    o_conv_start,
  output adc_pkg::chan_sel_t      o_conv_sel,
  input  wire logic               i_conv_done,
  input  wire logic [`RES_W-1:0]  i_conv_data,
  // status
  output logic                    o_ext_clk_mode,
  output logic                    o_seq_busy,
  // two-wire pins
  input  wire logic               i_scl,
  output logic                    o_scl_o,
  output logic                    o_scl_oe,
  input  wire logic               i_sda,
  output logic                    o_sda_o,
  output logic                    o_sda_oe
);
  localparam logic [`CODE_W-1:0] TOP_CH = FOUR_CHAN ? `TOP_SMALL : `TOP_LARGE;

  function automatic logic code_ok(input logic [`CODE_W-1:0] code,
                                   input logic single, input logic refm);
    code_ok = (code[3:2] != `RESERVED_HI) && // RL1 RL2
              !(single && refm && code == TOP_CH); // RL4
  endfunction

  function automatic adc_pkg::chan_sel_t decode(
      input logic [`CODE_W-1:0] code, input logic single, input logic refm);
    adc_pkg::chan_sel_t s;
    logic [`CODE_W-1:0] ev;
    logic [`CODE_W-1:0] od;
    s  = '0;
    ev = {code[3:1], 1'b0};
    od = {code[3:1], 1'b1};
    if (single) begin
      s.pos     = code; // RL1
      s.neg_gnd = 1'b1;
    end else begin
      s.pos = code[0] ? od : ev; // RL2
      s.neg = code[0] ? ev : od;
      if (refm && od == TOP_CH) begin
        // reference pin replaced by ground in the top pair
        if (code[0]) begin
          s.pos_gnd = 1'b1; // RL5
          s.pos     = '0;
        end else begin
          s.neg_gnd = 1'b1; // RL5
          s.neg     = '0;
        end
      end
    end
    return s;
  endfunction

  function automatic logic sync_pick(input logic s2, input logic s3,
                                     input logic f);
    sync_pick = (s2 == s3) ? s3 : f;
  endfunction

  // configuration (system domain)
  logic [`CODE_W-1:0] cfg_chan_r;
  logic [`CODE_W-1:0] cfg_chan_nxt;
  logic               cfg_sgl_r;
  logic               cfg_sgl_nxt;
  logic               cfg_ref_r;
  logic               cfg_ref_nxt;
  logic               cfg_ext_r;
  logic               cfg_ext_nxt;
  logic               cfg_scan_r;
  logic               cfg_scan_nxt;

  always_comb begin
    cfg_chan_nxt = cfg_chan_r;
    cfg_sgl_nxt  = cfg_sgl_r;
    cfg_ref_nxt  = cfg_ref_r;
    cfg_ext_nxt  = cfg_ext_r;
    cfg_scan_nxt = cfg_scan_r;
    if (i_cfg_write) begin
      cfg_chan_nxt = FOUR_CHAN ? (i_cfg_chan & `FOUR_CH_MASK) : i_cfg_chan; // RL3
      cfg_sgl_nxt  = i_cfg_single; // RL13 RL15
      cfg_ref_nxt  = i_cfg_ref_pin; // RL14 RL15
      cfg_ext_nxt  = i_cfg_ext_clk; // RL12
      cfg_scan_nxt = i_cfg_scan;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      cfg_chan_r <= `CFG_CHAN_RST;
      cfg_sgl_r  <= `CFG_SGL_RST; // RL13
      cfg_ref_r  <= `CFG_REF_RST;
      cfg_ext_r  <= `CFG_EXT_RST; // RL12
      cfg_scan_r <= `CFG_SCAN_RST;
    end else begin
      cfg_chan_r <= cfg_chan_nxt;
      cfg_sgl_r  <= cfg_sgl_nxt;
      cfg_ref_r  <= cfg_ref_nxt;
      cfg_ext_r  <= cfg_ext_nxt;
      cfg_scan_r <= cfg_scan_nxt;
    end
  end

  assign o_ext_clk_mode = cfg_ext_r;

  // request synchroniser (system domain)
  logic req_s1_r;
  logic req_s2_r;
  logic req_s3_r;
  logic req_f_r;
  logic req_f_nxt;
  logic link_req_tgl_r;
  logic link_kind_r;

  always_comb begin
    req_f_nxt = sync_pick(req_s2_r, req_s3_r, req_f_r);
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      req_s1_r <= 1'b0;
      req_s2_r <= 1'b0;
      req_s3_r <= 1'b0;
      req_f_r  <= 1'b0;
    end else begin
      req_s1_r <= link_req_tgl_r;
      req_s2_r <= req_s1_r;
      req_s3_r <= req_s2_r;
      req_f_r  <= req_f_nxt;
    end
  end

  // sequencer and answer (system domain)
  adc_pkg::seq_state_t     seq_r;
  adc_pkg::seq_state_t     seq_nxt;
  logic [`CODE_W-1:0]      cur_r;
  logic [`CODE_W-1:0]      cur_nxt;
  logic [`CODE_W-1:0]      lim_r;
  logic [`CODE_W-1:0]      lim_nxt;
  logic                    conv_start_nxt;
  adc_pkg::chan_sel_t      conv_sel_nxt;
  logic                    req_seen_r;
  logic                    req_seen_nxt;
  logic                    ack_tgl_r;
  logic                    ack_tgl_nxt;
  adc_pkg::result_word_t   ans_r;
  adc_pkg::result_word_t   ans_nxt;
  logic                    flush;
  logic                    push;
  logic                    pop;
  logic                    fifo_in_ready;
  logic                    fifo_out_valid;
  logic [`RES_W-1:0]       fifo_out_data;
  logic [`CODE_W-1:0]      lim_c;
  logic                    last_c;

  always_comb begin
    seq_nxt        = seq_r;
    cur_nxt        = cur_r;
    lim_nxt        = lim_r;
    conv_start_nxt = 1'b0;
    conv_sel_nxt   = o_conv_sel;
    req_seen_nxt   = req_seen_r;
    ack_tgl_nxt    = ack_tgl_r;
    ans_nxt        = ans_r;
    flush          = 1'b0;
    push           = 1'b0;
    pop            = 1'b0;
    lim_c          = (cfg_chan_r > TOP_CH) ? TOP_CH : cfg_chan_r;
    if (cfg_sgl_r && cfg_ref_r && lim_c == TOP_CH) begin
      lim_c = TOP_CH - `SGL_STEP; // RL4 RL14
    end
    last_c = cfg_sgl_r ? (cur_r >= lim_r) : (cur_r[3:1] >= lim_r[3:1]);
    unique case (seq_r)
      adc_pkg::SEQ_IDLE: begin
        if (req_f_r != req_seen_r && link_kind_r) begin
          // a new read drops stale results
          req_seen_nxt = req_f_r; // RL7
          ack_tgl_nxt  = ~ack_tgl_r;
          flush        = 1'b1;
          seq_nxt      = adc_pkg::SEQ_ISSUE;
          if (cfg_scan_r) begin
            lim_nxt = lim_c;
            cur_nxt = cfg_sgl_r ? '0 : {3'h0, cfg_chan_r[0]};
          end else begin
            lim_nxt = cfg_chan_r;
            cur_nxt = cfg_chan_r;
          end
        end
      end
      adc_pkg::SEQ_ISSUE: begin
        if (!code_ok(cur_r, cfg_sgl_r, cfg_ref_r)) begin
          if (last_c) begin
            seq_nxt = adc_pkg::SEQ_IDLE;
          end else begin
            cur_nxt = cur_r + (cfg_sgl_r ? `SGL_STEP : `DIFF_STEP);
          end
        end else if (fifo_in_ready) begin
          conv_start_nxt = 1'b1;
          conv_sel_nxt   = decode(cur_r, cfg_sgl_r, cfg_ref_r);
          seq_nxt        = adc_pkg::SEQ_WAIT;
        end
      end
      adc_pkg::SEQ_WAIT: begin
        if (i_conv_done) begin
          push = 1'b1;
          if (last_c) begin
            seq_nxt = adc_pkg::SEQ_IDLE;
          end else begin
            cur_nxt = cur_r + (cfg_sgl_r ? `SGL_STEP : `DIFF_STEP); // RL6
            seq_nxt = adc_pkg::SEQ_ISSUE;
          end
        end
      end
    endcase
    // a word request waits for a result or the end of the scan
    if (req_f_r != req_seen_r && !link_kind_r &&
        (fifo_out_valid || seq_r == adc_pkg::SEQ_IDLE)) begin
      req_seen_nxt = req_f_r;
      ack_tgl_nxt  = ~ack_tgl_r;
      ans_nxt      = {fifo_out_valid, fifo_out_data};
      pop          = fifo_out_valid;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      seq_r        <= adc_pkg::SEQ_IDLE;
      cur_r        <= '0;
      lim_r        <= '0;
      o_conv_start <= 1'b0;
      o_conv_sel   <= '0;
      o_seq_busy   <= 1'b0;
      req_seen_r   <= 1'b0;
      ack_tgl_r    <= 1'b0;
      ans_r        <= '0;
    end else begin
      seq_r        <= seq_nxt;
      cur_r        <= cur_nxt;
      lim_r        <= lim_nxt;
      o_conv_start <= conv_start_nxt;
      o_conv_sel   <= conv_sel_nxt;
      o_seq_busy   <= (seq_nxt != adc_pkg::SEQ_IDLE);
      req_seen_r   <= req_seen_nxt;
      ack_tgl_r    <= ack_tgl_nxt;
      ans_r        <= ans_nxt;
    end
  end

  result_fifo #(
    .WIDTH (`RES_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (i_ref_clk),
    .i_reset_n   (i_reset_n),
    .i_flush     (flush),
    .i_in_valid  (push),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (i_conv_data),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (pop),
    .o_out_data  (fifo_out_data)
  );

  // link domain: reset, pin and answer-toggle synchronisers
  logic [2:0] lrst_r;
  logic       lrst_n;
  logic [2:0] ls1_r;
  logic [2:0] ls2_r;
  logic [2:0] ls3_r;
  logic [2:0] lf_r;
  logic [2:0] lf_nxt;
  logic [2:0] lq_r;

  assign lrst_n = lrst_r[2];

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      lf_nxt[i] = sync_pick(ls2_r[i], ls3_r[i], lf_r[i]);
    end
  end

  always_ff @(posedge i_link_clk) begin
    lrst_r <= {lrst_r[1:0], i_reset_n};
  end

  always_ff @(posedge i_link_clk) begin
    if (!lrst_n) begin
      ls1_r <= 3'h3;
      ls2_r <= 3'h3;
      ls3_r <= 3'h3;
      lf_r  <= 3'h3;
      lq_r  <= 3'h3;
    end else begin
      ls1_r <= {ack_tgl_r, i_sda, i_scl};
      ls2_r <= ls1_r;
      ls3_r <= ls2_r;
      lf_r  <= lf_nxt;
      lq_r  <= lf_r;
    end
  end

  // bit 0 scl, bit 1 sda, bit 2 answer toggle
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  assign scl_rise = lf_r[0] && !lq_r[0];
  assign scl_fall = !lf_r[0] && lq_r[0];
  assign start_c  = lf_r[0] && lq_r[0] && lq_r[1] && !lf_r[1];
  assign stop_c   = lf_r[0] && lq_r[0] && !lq_r[1] && lf_r[1];

  // link domain: two-wire slave
  adc_pkg::link_state_t lst_r;
  adc_pkg::link_state_t lst_nxt;
  logic [3:0]           bit_r;
  logic [3:0]           bit_nxt;
  logic [7:0]           sh_r;
  logic [7:0]           sh_nxt;
  logic [`WORD_W-1:0]   word_r;
  logic [`WORD_W-1:0]   word_nxt;
  logic                 second_r;
  logic                 second_nxt;
  logic                 acked_r;
  logic                 acked_nxt;
  logic                 kind_nxt;
  logic                 req_tgl_nxt;
  logic                 sda_oe_nxt;
  logic                 scl_oe_nxt;

  always_comb begin
    lst_nxt     = lst_r;
    bit_nxt     = bit_r;
    sh_nxt      = sh_r;
    word_nxt    = word_r;
    second_nxt  = second_r;
    acked_nxt   = acked_r;
    kind_nxt    = link_kind_r;
    req_tgl_nxt = link_req_tgl_r;
    sda_oe_nxt  = o_sda_oe;
    scl_oe_nxt  = o_scl_oe;
    if (start_c) begin
      lst_nxt    = adc_pkg::LK_ADDR; // RL8
      bit_nxt    = '0;
      sda_oe_nxt = 1'b0;
      scl_oe_nxt = 1'b0;
    end else if (stop_c) begin
      lst_nxt    = adc_pkg::LK_IDLE;
      sda_oe_nxt = 1'b0;
      scl_oe_nxt = 1'b0;
    end else begin
      unique case (lst_r)
        adc_pkg::LK_IDLE: begin
        end
        adc_pkg::LK_ADDR: begin
          if (scl_rise) begin
            sh_nxt  = {sh_r[6:0], lf_r[1]};
            bit_nxt = bit_r + 4'h1;
          end else if (scl_fall && bit_r == `BIT_ADDR_END) begin
            if (sh_r[7:1] == SLAVE_ADDR && sh_r[0] == `RW_READ) begin
              sda_oe_nxt = 1'b1; // RL8
              kind_nxt   = 1'b1;
              lst_nxt    = adc_pkg::LK_ADDR_ACK;
            end else begin
              // writes and foreign addresses are left alone
              lst_nxt = adc_pkg::LK_IDLE;
            end
          end
        end
        adc_pkg::LK_ADDR_ACK: begin
          if (scl_fall) begin
            sda_oe_nxt  = 1'b0;
            scl_oe_nxt  = 1'b1;
            req_tgl_nxt = ~link_req_tgl_r; // RL7
            lst_nxt     = adc_pkg::LK_FETCH;
          end
        end
        adc_pkg::LK_REQ: begin
          // a cycle after the kind change, so it has settled
          req_tgl_nxt = ~link_req_tgl_r;
          lst_nxt     = adc_pkg::LK_FETCH;
        end
        adc_pkg::LK_FETCH: begin
          // scl is held low until the answer is back
          if (lf_r[2] == link_req_tgl_r) begin
            if (link_kind_r) begin
              kind_nxt = 1'b0;
              lst_nxt  = adc_pkg::LK_REQ;
            end else begin
              word_nxt   = ans_r.present ? {`LEAD_ONES, ans_r.data}
                                         : `ALL_ONES; // RL9
              sda_oe_nxt = 1'b0;
              bit_nxt    = '0;
              second_nxt = 1'b0;
              scl_oe_nxt = 1'b0;
              lst_nxt    = adc_pkg::LK_TX;
            end
          end
        end
        adc_pkg::LK_TX: begin
          if (scl_fall) begin
            word_nxt = {word_r[`WORD_W-2:0], 1'b1};
            bit_nxt  = bit_r + 4'h1;
            if (bit_r == `BIT_LAST) begin
              sda_oe_nxt = 1'b0;
              acked_nxt  = 1'b0;
              lst_nxt    = adc_pkg::LK_RX_ACK;
            end else begin
              sda_oe_nxt = !word_r[`WORD_W-2]; // RL9
            end
          end
        end
        adc_pkg::LK_RX_ACK: begin
          if (scl_rise) begin
            if (lf_r[1]) begin
              lst_nxt = adc_pkg::LK_IDLE; // RL10 RL11
            end else begin
              acked_nxt = 1'b1; // RL10
            end
          end else if (scl_fall && acked_r) begin
            bit_nxt = '0;
            if (!second_r) begin
              second_nxt = 1'b1;
              sda_oe_nxt = !word_r[`WORD_W-1];
              lst_nxt    = adc_pkg::LK_TX;
            end else begin
              scl_oe_nxt = 1'b1;
              lst_nxt    = adc_pkg::LK_REQ;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_link_clk) begin
    if (!lrst_n) begin
      lst_r          <= adc_pkg::LK_IDLE;
      bit_r          <= '0;
      sh_r           <= '0;
      word_r         <= `ALL_ONES;
      second_r       <= 1'b0;
      acked_r        <= 1'b0;
      link_kind_r    <= 1'b0;
      link_req_tgl_r <= 1'b0;
      o_sda_oe       <= 1'b0;
      o_scl_oe       <= 1'b0;
      o_sda_o        <= 1'b0;
      o_scl_o        <= 1'b0;
    end else begin
      lst_r          <= lst_nxt;
      bit_r          <= bit_nxt;
      sh_r           <= sh_nxt;
      word_r         <= word_nxt;
      second_r       <= second_nxt;
      acked_r        <= acked_nxt;
      link_kind_r    <= kind_nxt;
      link_req_tgl_r <= req_tgl_nxt;
      o_sda_oe       <= sda_oe_nxt;
      o_scl_oe       <= scl_oe_nxt;
      o_sda_o        <= 1'b0;
      o_scl_o        <= 1'b0;
    end
  end
endmodule

// [adc_pkg.sv]
`include "adc_consts.svh"
package adc_pkg;
  typedef struct packed {
    logic                 pos_gnd;
    logic [`CODE_W-1:0]   pos;
    logic                 neg_gnd;
    logic [`CODE_W-1:0]   neg;
  } chan_sel_t;

  typedef struct packed {
    logic                 present;
    logic [`RES_W-1:0]    data;
  } result_word_t;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_ISSUE,
    SEQ_WAIT
  } seq_state_t;

  typedef enum logic [2:0] {
    LK_IDLE,
    LK_ADDR,
    LK_ADDR_ACK,
    LK_REQ,
    LK_FETCH,
    LK_TX,
    LK_RX_ACK
  } link_state_t;
endpackage

// [adc_readout_sva.sv]
module adc_readout_sva (
  input wire logic               i_ref_clk,
  input wire logic               i_reset_n,
  input wire logic               i_cfg_write,
  input wire logic               i_cfg_ext_clk,
  input wire logic               o_conv_start,
  input wire adc_pkg::chan_sel_t o_conv_sel,
  input wire logic               o_seq_busy,
  input wire logic               o_ext_clk_mode
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  logic [3:0] last_pos_r;
  logic       last_diff_r;
  // stride counts only within one run
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n || (!o_seq_busy && !o_conv_start)) begin
      last_diff_r <= 1'b0;
    end else if (o_conv_start) begin
      last_diff_r <= !o_conv_sel.pos_gnd && !o_conv_sel.neg_gnd;
    end
    if (o_conv_start) begin
      last_pos_r <= o_conv_sel.pos;
    end
  end
  sequence diff_start;
    o_conv_start && !o_conv_sel.pos_gnd && !o_conv_sel.neg_gnd;
  endsequence
  a_reset_quiet: assert property ($rose(i_reset_n) |->
    !o_conv_start && !o_seq_busy && !o_ext_clk_mode)
    else $error("outputs not cleared by reset");
  a_clk_src_load: assert property (i_cfg_write |=>
    o_ext_clk_mode == $past(i_cfg_ext_clk))
    else $error("clock source bit not loaded");
  a_clk_src_hold: assert property (!i_cfg_write |=>
    $stable(o_ext_clk_mode)) else $error("clock source bit drifted");
  a_start_pulse: assert property (o_conv_start |=> !o_conv_start)
    else $error("start longer than one cycle");
  a_sel_held: assert property (!o_conv_start |-> $stable(o_conv_sel))
    else $error("selection changed between starts");
  a_single_map: assert property (o_conv_start && o_conv_sel.neg_gnd |->
    !o_conv_sel.pos_gnd && o_conv_sel.pos <= 4'hb)
    else $error("bad single-ended selection");
  a_diff_pair: assert property (diff_start |->
    (o_conv_sel.pos ^ o_conv_sel.neg) == 4'h1 && o_conv_sel.pos <= 4'hb)
    else $error("bad differential pair");
  a_ref_pair: assert property (o_conv_start && o_conv_sel.pos_gnd |->
    !o_conv_sel.neg_gnd && o_conv_sel.neg == 4'ha)
    else $error("bad reference pair");
  a_scan_stride: assert property (diff_start and last_diff_r |->
    o_conv_sel.pos == last_pos_r + 4'h2) else $error("bad scan stride");
endmodule

// [i2c_master_model.sv]
module i2c_master_model (
  // wire levels
  input  wire logic i_scl,
  input  wire logic i_sda,
  // high pulls the wire low
  output logic      o_scl_low,
  output logic      o_sda_low
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF = 120;
  logic [15:0] got [0:7];
  logic        addr_ack;
  initial begin
    o_scl_low = 1'b0;
    o_sda_low = 1'b0;
  end
  // sda moves mid-low, never with scl; each rise waits out stretching
  task automatic put_bit(input logic b);
    #(HALF / 2) o_sda_low = !b;
    #(HALF / 2) o_scl_low = 1'b0;
    wait (i_scl);
    #HALF o_scl_low = 1'b1;
  endtask
  task automatic get_bit(output logic b);
    #(HALF / 2) o_sda_low = 1'b0;
    #(HALF / 2) o_scl_low = 1'b0;
    wait (i_scl);
    b = i_sda;
    #HALF o_scl_low = 1'b1;
  endtask
  task automatic xfer(input logic [7:0] hdr, input int n);
    logic b;
    o_sda_low = 1'b1;
    #HALF o_scl_low = 1'b1;
    for (int i = 7; i >= 0; i--) put_bit(hdr[i]);
    get_bit(b);
    addr_ack = !b;
    for (int w = 0; w < n && addr_ack; w++) begin
      for (int i = 15; i >= 0; i--) begin
        get_bit(got[w][i]);
        if (i == 8) put_bit(1'b0);
      end
      put_bit(w == n - 1);
    end
    #(HALF / 2) o_sda_low = 1'b1;
    #(HALF / 2) o_scl_low = 1'b0;
    wait (i_scl);
    #HALF o_sda_low = 1'b0;
    #HALF;
  endtask
endmodule

// [result_fifo.sv]
module result_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 4
)(
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_reset_n,
  input  wire logic             i_flush,
  // fill side
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  // drain side
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0]    wr_r;
  logic [PW-1:0]    wr_nxt;
  logic [PW-1:0]    rd_r;
  logic [PW-1:0]    rd_nxt;
  logic [CW-1:0]    cnt_r;
  logic [CW-1:0]    cnt_nxt;
  logic             push;
  logic             pop;

  assign o_in_ready  = (cnt_r != FULL_CNT);
  assign o_out_valid = (cnt_r != '0);
  assign o_out_data  = mem_r[rd_r];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = i_out_ready && o_out_valid;

  always_comb begin
    wr_nxt  = wr_r;
    rd_nxt  = rd_r;
    cnt_nxt = cnt_r;
    if (i_flush) begin
      wr_nxt  = '0;
      rd_nxt  = '0;
      cnt_nxt = '0;
    end else begin
      if (push) begin
        wr_nxt = (wr_r == LAST_PTR) ? '0 : wr_r + PW'(1);
      end
      if (pop) begin
        rd_nxt = (rd_r == LAST_PTR) ? '0 : rd_r + PW'(1);
      end
      if (push && !pop) begin
        cnt_nxt = cnt_r + CW'(1);
      end else if (pop && !push) begin
        cnt_nxt = cnt_r - CW'(1);
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      wr_r  <= wr_nxt;
      rd_r  <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // storage needs no reset; only words counted valid are ever read
  always_ff @(posedge i_clk) begin
    if (push && !i_flush) begin
      mem_r[wr_r] <= i_in_data;
    end
  end
endmodule

// [tb_adc_i2c_readout.sv]
module tb_adc_i2c_readout;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [6:0] ADDR = 7'h2a;
  logic               i_ref_clk = 1'b0;
  logic               i_link_clk = 1'b0;
  logic               i_reset_n = 1'b0;
  logic               i_cfg_write = 1'b0;
  logic [3:0]         i_cfg_chan = 4'h0;
  logic               i_cfg_single = 1'b1;
  logic               i_cfg_ref_pin = 1'b0;
  logic               i_cfg_ext_clk = 1'b0;
  logic               i_cfg_scan = 1'b0;
  logic               i_conv_done = 1'b0;
  logic [9:0]         i_conv_data = 10'h000;
  logic               o_conv_start, o_ext_clk_mode, o_seq_busy;
  adc_pkg::chan_sel_t o_conv_sel;
  logic               o_scl_o, o_scl_oe, o_sda_o, o_sda_oe;
  logic               m_scl_low, m_sda_low;
  wire logic          scl_line = !(m_scl_low || o_scl_oe);
  wire logic          sda_line = !(m_sda_low || o_sda_oe);
  int                 fail_count = 0;
  int                 check_count = 0;
  int                 starts = 0;
  int                 pend = 0;
  int                 cycles = 0;
  always #2.5 i_ref_clk = !i_ref_clk;
  initial #1.1 forever #7.5 i_link_clk = !i_link_clk;
  adc_i2c_readout #(.SLAVE_ADDR(ADDR)) uut (
    .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_link_clk(i_link_clk),
    .i_cfg_write(i_cfg_write), .i_cfg_chan(i_cfg_chan),
    .i_cfg_single(i_cfg_single), .i_cfg_ref_pin(i_cfg_ref_pin),
    .i_cfg_ext_clk(i_cfg_ext_clk), .i_cfg_scan(i_cfg_scan),
    .o_conv_start(o_conv_start), .o_conv_sel(o_conv_sel),
    .i_conv_done(i_conv_done), .i_conv_data(i_conv_data),
    .o_ext_clk_mode(o_ext_clk_mode), .o_seq_busy(o_seq_busy),
    .i_scl(scl_line), .o_scl_o(o_scl_o), .o_scl_oe(o_scl_oe),
    .i_sda(sda_line), .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe));
  i2c_master_model pm (.i_scl(scl_line), .i_sda(sda_line),
    .o_scl_low(m_scl_low), .o_sda_low(m_sda_low));
  function automatic logic [15:0] exp_word(logic [3:0] c, logic sgl, r);
    if (c[3:2] == 2'b11 || (sgl && r && c == 4'hb)) return 16'hffff;
    if (sgl) return {6'h3f, 1'b0, c, 5'h10};
    if (r && c[3:1] == 3'b101)
      return c[0] ? {6'h3f, 6'h20, 4'ha} : {6'h3f, 1'b0, 4'ha, 5'h10};
    return {6'h3f, 1'b0, c, 1'b0, c ^ 4'h1};
  endfunction
  // converter stand-in: answers five cycles after each start
  always @(posedge i_ref_clk) begin
    if (o_conv_start) begin
      starts <= starts + 1;
      pend <= 5;
    end else if (pend != 0) begin
      pend <= pend - 1;
    end
    i_conv_done <= #1 (pend == 1 && !o_conv_start);
    i_conv_data <= #1 o_conv_sel;
    if (++cycles == 90000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  task automatic cmp(input logic [15:0] got, exp, input string what);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic cfg(input logic [3:0] c, input logic sgl, r, ext, scan);
    @(posedge i_ref_clk) #1;
    {i_cfg_chan, i_cfg_single, i_cfg_ref_pin} = {c, sgl, r};
    {i_cfg_ext_clk, i_cfg_scan, i_cfg_write} = {ext, scan, 1'b1};
    @(posedge i_ref_clk) #1;
    i_cfg_write = 1'b0;
    @(posedge i_ref_clk) #1;
  endtask
  task automatic read1(input logic [15:0] exp, input string what);
    pm.xfer({ADDR, 1'b1}, 1);
    cmp(16'(pm.addr_ack), 16'h1, "address ack");
    cmp(pm.got[0], exp, what);
    cmp(16'(o_sda_oe), 16'h0, "sda after nack");
  endtask
  task automatic t_defaults();
    cmp(16'(o_ext_clk_mode), 16'h0, "clock source at reset");
    for (int k = 0; k < 2; k++)
      read1(exp_word(4'h0, 1'b1, 1'b0), "power-up channel");
    cmp(16'(starts), 16'h2, "one conversion per read");
  endtask
  task automatic t_clk_src();
    for (int k = 1; k >= 0; k--) begin
      cfg(4'h0, 1'b1, 1'b0, 1'(k), 1'b0);
      cmp(16'(o_ext_clk_mode), 16'(k), "clock source");
    end
  endtask
  task automatic t_table();
    int s;
    for (int m = 0; m < 2; m++)
      for (int c = 0; c < 16; c++) begin
        cfg(4'(c), 1'(m), 1'b0, 1'b0, 1'b0);
        s = starts;
        repeat (20) @(posedge i_ref_clk);
        cmp(16'(starts - s), 16'h0, "stray conversion");
        read1(exp_word(4'(c), 1'(m), 1'b0), "channel code");
      end
  endtask
  task automatic t_ref();
    for (int c = 10; c < 12; c++)
      for (int m = 0; m < 2; m++) begin
        cfg(4'(c), 1'(m), 1'b1, 1'b0, 1'b0);
        read1(exp_word(4'(c), 1'(m), 1'b1), "ref pin mode");
      end
  endtask
  task automatic t_scan();
    for (int m = 0; m < 2; m++) begin
      cfg(m ? 4'h3 : 4'h6, 1'(m), 1'b0, 1'b0, 1'b1);
      pm.xfer({ADDR, 1'b1}, 4);
      for (int w = 0; w < 4; w++)
        cmp(pm.got[w], exp_word(4'(w << !m), 1'(m), 1'b0), "scan");
    end
  endtask
  task automatic t_bad_addr();
    int s;
    s = starts;
    pm.xfer({ADDR ^ 7'h01, 1'b1}, 1);
    cmp(16'(pm.addr_ack), 16'h0, "foreign address");
    pm.xfer({ADDR, 1'b0}, 1);
    cmp(16'(pm.addr_ack), 16'h0, "write request");
    cmp(16'(starts - s), 16'h0, "stray conversion");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // reset covers four link-clock edges for the resync
  initial begin
    repeat (12) @(posedge i_ref_clk);
    #1 i_reset_n = 1'b1;
    repeat (16) @(posedge i_ref_clk);
    t_defaults();
    t_clk_src();
    t_table();
    t_ref();
    t_scan();
    t_bad_addr();
    tally_and_finish();
  end
endmodule
bind adc_i2c_readout adc_readout_sva chk (
  .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_cfg_write(i_cfg_write),
  .i_cfg_ext_clk(i_cfg_ext_clk), .o_conv_start(o_conv_start),
  .o_conv_sel(o_conv_sel), .o_seq_busy(o_seq_busy),
  .o_ext_clk_mode(o_ext_clk_mode));
